// ---- include/ckb_defs.svh ----
`ifndef CKB_DEFS_SVH
`define CKB_DEFS_SVH

// Full key common field positions
`define CKB_TYPE_LSB        0
`define CKB_LOOKUP_LSB      2
`define CKB_PORTS           12
`define CKB_PMASK_LSB       4
`define CKB_RSVD_LSB        16
`define CKB_RSVD_W          9
`define CKB_OAM_BIT         25
`define CKB_MC_BIT          26
`define CKB_BC_BIT          27
`define CKB_IPMC_BIT        28
`define CKB_TAG1_BIT        29
`define CKB_TAG2_BIT        30
`define CKB_TPID_BIT        31
`define CKB_VID_LSB         32
`define CKB_DEI_BIT         44
`define CKB_PCP_LSB         45
`define CKB_ITPID_BIT       48
`define CKB_IVID_LSB        49
`define CKB_IDEI_BIT        61
`define CKB_IPCP_LSB        62
`define CKB_FULL_W          65
// IPv4 five-tuple half key tail
`define CKB_RNG_LSB         148
`define CKB_RNG_N           8
`define CKB_PAY_LSB         156
`define CKB_HALF_W          188
// Match constants
`define CKB_OAM_ETYPE       16'h8902
`define CKB_V4MC_PREFIX     25'h0200BC
`define CKB_V6MC_PREFIX     16'h3333
`define CKB_BCAST           48'hFFFFFFFFFFFF
`define CKB_MC_BIT_IN_MAC   40

`endif

// ---- include/ckb_pkg.sv ----
package ckb_pkg;
	typedef enum logic [1:0] {
		CKB_NORMAL_IPV6,
		CKB_SEVEN_TUPLE,
		CKB_IPV6_FIVE_TUPLE
	} ckb_full_type_t;

	typedef enum logic [2:0] {
		CKB_RNG_SRC,
		CKB_RNG_DST,
		CKB_RNG_EITHER,
		CKB_RNG_VID,
		CKB_RNG_DSCP
	} ckb_rng_kind_t;

	typedef enum logic [0:0] {
		CKB_IDLE,
		CKB_HOLD
	} ckb_state_t;
endpackage

// ---- rtl/ckb_key_builder.sv ----
// Behaviour
// - Full key type code at bit 0
// - Lookup index at bit 2
// - One-hot ingress port mask at bit 4 for ports 0 to 11
// - OAM EtherType 0x8902 sets bit 25
// - Destination MAC bit 40 sets bit 26
// - Broadcast destination sets bit 27
// - IPv4/IPv6 multicast MAC sets bit 28
// - One/two Q-tags set bits 29/30
// - Tag type at bit 31, selectable tag
// - VID, DEI, PCP from tag or port
// - Inner tag fields when double tagged
// - Range match mask at bit 148
// - Range checkers on ports, VID, DSCP
// - IP payload word at bit 156
`timescale 1ns/100ps
`include "ckb_defs.svh"

module ckb_key_builder (
	// Clock and reset
	input  wire logic                         clk,
	input  wire logic                         sys_rst,
	// Frame descriptor from parser
	input  wire logic                         frm_valid,
	input  wire ckb_pkg::ckb_full_type_t      full_key_type,
	input  wire logic [1:0]                   lookup_idx,
	input  wire logic [3:0]                   ingress_port,
	input  wire logic [47:0]                  dmac,
	input  wire logic [15:0]                  etype,
	input  wire logic                         is_ipv4,
	input  wire logic                         is_ipv6,
	input  wire logic [1:0]                   tag_count,
	input  wire logic                         outer_tag_type,
	input  wire logic [11:0]                  outer_vid,
	input  wire logic                         outer_dei,
	input  wire logic [2:0]                   outer_pcp,
	input  wire logic                         inner_tag_type,
	input  wire logic [11:0]                  inner_vlan_id,
	input  wire logic                         inner_drop_eligible,
	input  wire logic [2:0]                   inner_priority,
	input  wire logic [15:0]                  src_l4_port,
	input  wire logic [15:0]                  dst_l4_port,
	input  wire logic [5:0]                   dscp_xlated,
	input  wire logic [31:0]                  ip_payload_word,
	// Port configuration
	input  wire logic                         normal_key_sel,
	input  wire logic                         inner_tag_select,
	input  wire logic [11:0]                  port_vid,
	input  wire logic                         port_dei,
	input  wire logic [2:0]                   port_pcp,
	// Range checker configuration, 16-bit bounds per checker
	input  wire logic [`CKB_RNG_N*3-1:0]      rng_kind,
	input  wire logic [`CKB_RNG_N*16-1:0]     rng_lo,
	input  wire logic [`CKB_RNG_N*16-1:0]     rng_hi,
	// Key to match stage
	output logic                              key_valid,
	input  wire logic                         key_taken,
	output logic [`CKB_FULL_W-1:0]            full_key,
	output logic [`CKB_HALF_W-1:0]            half_key,
	output logic                              frm_ready
);
	import ckb_pkg::*;

	logic [`CKB_FULL_W-1:0]  full_d;
	logic [`CKB_HALF_W-1:0]  half_d;
	logic [`CKB_RNG_N-1:0]   rng_hit;
	logic                    use_inner;
	logic [15:0]             vid_ext;
	logic                    accept;
	ckb_state_t              state_q;

	assign accept = frm_valid && frm_ready;

	// Untagged frames range-check the port VID
	assign vid_ext = {4'h0, (tag_count != 2'h0) ? outer_vid : port_vid};

	genvar g;
	generate
		for (g = 0; g < `CKB_RNG_N; g++) begin : g_rng
			logic [15:0] lo;
			logic [15:0] hi;
			logic        s_in;
			logic        d_in;
			logic        v_in;
			logic        c_in;
			assign lo   = rng_lo[g*16 +: 16];
			assign hi   = rng_hi[g*16 +: 16];
			assign s_in = (src_l4_port >= lo) && (src_l4_port <= hi);
			assign d_in = (dst_l4_port >= lo) && (dst_l4_port <= hi);
			assign v_in = (vid_ext >= lo) && (vid_ext <= hi);
			assign c_in = ({10'h000, dscp_xlated} >= lo) && ({10'h000, dscp_xlated} <= hi);
			always_comb begin
				unique case (ckb_rng_kind_t'(rng_kind[g*3 +: 3]))
					CKB_RNG_SRC:    rng_hit[g] = s_in;
					CKB_RNG_DST:    rng_hit[g] = d_in;
					CKB_RNG_EITHER: rng_hit[g] = s_in || d_in;
					CKB_RNG_VID:    rng_hit[g] = v_in;
					CKB_RNG_DSCP:   rng_hit[g] = c_in;
					default:        rng_hit[g] = 1'b0;
				endcase
			end
		end
	endgenerate

	// Normal key may pick the inner tag when double tagged
	assign use_inner = normal_key_sel && inner_tag_select && (tag_count >= 2'h2);

	always_comb begin
		full_d = '0;
		full_d[`CKB_TYPE_LSB +: 2]   = full_key_type;
		full_d[`CKB_LOOKUP_LSB +: 2] = lookup_idx;
		full_d[`CKB_PMASK_LSB +: `CKB_PORTS] = 12'h001 << ingress_port;
		// Reserved field driven zero; entries must mask it
		full_d[`CKB_RSVD_LSB +: `CKB_RSVD_W] = 9'h000;
		full_d[`CKB_OAM_BIT] = (etype == `CKB_OAM_ETYPE);
		full_d[`CKB_MC_BIT]  = dmac[`CKB_MC_BIT_IN_MAC];
		full_d[`CKB_BC_BIT]  = (dmac == `CKB_BCAST);
		full_d[`CKB_IPMC_BIT] = (is_ipv4 && dmac[47:23] == `CKB_V4MC_PREFIX)
			|| (is_ipv6 && dmac[47:32] == `CKB_V6MC_PREFIX);
		full_d[`CKB_TAG1_BIT] = (tag_count >= 2'h1);
		full_d[`CKB_TAG2_BIT] = (tag_count >= 2'h2);
		if (use_inner) begin
			full_d[`CKB_TPID_BIT]       = inner_tag_type;
			full_d[`CKB_VID_LSB +: 12]  = inner_vlan_id;
			full_d[`CKB_DEI_BIT]        = inner_drop_eligible;
			full_d[`CKB_PCP_LSB +: 3]   = inner_priority;
		end else if (tag_count != 2'h0) begin
			full_d[`CKB_TPID_BIT]       = outer_tag_type;
			full_d[`CKB_VID_LSB +: 12]  = outer_vid;
			full_d[`CKB_DEI_BIT]        = outer_dei;
			full_d[`CKB_PCP_LSB +: 3]   = outer_pcp;
		end else begin
			full_d[`CKB_VID_LSB +: 12]  = port_vid;
			full_d[`CKB_DEI_BIT]        = port_dei;
			full_d[`CKB_PCP_LSB +: 3]   = port_pcp;
		end
		if (tag_count >= 2'h2) begin
			full_d[`CKB_ITPID_BIT]      = inner_tag_type;
			full_d[`CKB_IVID_LSB +: 12] = inner_vlan_id;
			full_d[`CKB_IDEI_BIT]       = inner_drop_eligible;
			full_d[`CKB_IPCP_LSB +: 3]  = inner_priority;
		end
	end

	always_comb begin
		half_d = '0;
		half_d[`CKB_FULL_W-1:0] = full_d;
		half_d[`CKB_RNG_LSB +: `CKB_RNG_N] = rng_hit;
		half_d[`CKB_PAY_LSB +: 32] = ip_payload_word;
	end

	// Handshake: one key in flight, stable until taken
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q   <= CKB_IDLE;
			key_valid <= 1'b0;
			frm_ready <= 1'b1;
		end else begin
			unique case (state_q)
				CKB_IDLE: begin
					if (frm_valid) begin
						state_q   <= CKB_HOLD;
						key_valid <= 1'b1;
						frm_ready <= 1'b0;
					end
				end
				CKB_HOLD: begin
					if (key_taken) begin
						state_q   <= CKB_IDLE;
						key_valid <= 1'b0;
						frm_ready <= 1'b1;
					end
				end
			endcase
		end
	end

	// Both keys latched together so fields stay consistent
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			full_key <= '0;
			half_key <= '0;
		end else if (accept) begin
			full_key <= full_d;
			half_key <= half_d;
		end
	end

	property p_hold;
		@(posedge clk) disable iff (sys_rst) key_valid && !key_taken
			|=> key_valid && $stable(full_key) && $stable(half_key);
	endproperty
	a_hold: assert property (p_hold)
		else $error("key changed before taken");
	property p_onehot;
		@(posedge clk) disable iff (sys_rst) key_valid |-> $onehot(full_key[`CKB_PMASK_LSB +: `CKB_PORTS]);
	endproperty
	a_onehot: assert property (p_onehot)
		else $error("port mask not one-hot");
	property p_bc;
		@(posedge clk) disable iff (sys_rst) accept |=> full_key[`CKB_BC_BIT] == ($past(dmac) == `CKB_BCAST);
	endproperty
	a_bc: assert property (p_bc)
		else $error("broadcast flag wrong");
	property p_mc;
		@(posedge clk) disable iff (sys_rst) accept |=> full_key[`CKB_MC_BIT] == $past(dmac[40]);
	endproperty
	a_mc: assert property (p_mc)
		else $error("multicast flag wrong");
	property p_oam;
		@(posedge clk) disable iff (sys_rst) accept |=> full_key[`CKB_OAM_BIT] == ($past(etype) == `CKB_OAM_ETYPE);
	endproperty
	a_oam: assert property (p_oam)
		else $error("oam flag wrong");
	property p_tags;
		@(posedge clk) disable iff (sys_rst) accept |=> full_key[`CKB_TAG1_BIT] == ($past(tag_count) != 2'h0)
			&& full_key[`CKB_TAG2_BIT] == ($past(tag_count) >= 2'h2);
	endproperty
	a_tags: assert property (p_tags)
		else $error("tag flags wrong");
	property p_inner;
		@(posedge clk) disable iff (sys_rst) key_valid && !full_key[`CKB_TAG2_BIT] |-> full_key[64:48] == 17'h00000;
	endproperty
	a_inner: assert property (p_inner)
		else $error("inner fields set without double tag");
	property p_pay;
		@(posedge clk) disable iff (sys_rst) accept |=> half_key[`CKB_PAY_LSB +: 32] == $past(ip_payload_word);
	endproperty
	a_pay: assert property (p_pay)
		else $error("payload word wrong");
	property p_type;
		@(posedge clk) disable iff (sys_rst) accept |=> full_key[1:0] == $past(full_key_type)
			&& full_key[3:2] == $past(lookup_idx);
	endproperty
	a_type: assert property (p_type)
		else $error("key type or lookup wrong");

	c_take: cover property (@(posedge clk) key_valid ##1 key_taken ##1 !key_valid);
	c_dbl:  cover property (@(posedge clk) key_valid && full_key[`CKB_TAG2_BIT]);
	c_rng:  cover property (@(posedge clk) key_valid && half_key[`CKB_RNG_LSB +: `CKB_RNG_N] != 8'h00);
endmodule

// ---- verification/ckb_key_builder_test.sv ----
`timescale 1ns/100ps
`include "ckb_defs.svh"
module ckb_key_builder_test;
	import ckb_pkg::*;
	logic clk, sys_rst, frm_valid, is_ipv4, is_ipv6, ott, odei, inner_tag_type, inner_drop_eligible;
	logic normal_key_sel, inner_tag_select, port_dei, key_valid, key_taken, frm_ready, slow;
	ckb_full_type_t full_key_type;
	logic [1:0]     lookup_idx, tag_count;
	logic [3:0]     ingress_port;
	logic [47:0]    dmac;
	logic [15:0]    etype, src_l4_port, dst_l4_port;
	logic [11:0]    ovid, inner_vlan_id, port_vid;
	logic [2:0]     opcp, inner_priority, port_pcp;
	logic [5:0]     dscp_xlated;
	logic [31:0]    ip_payload_word;
	logic [23:0]    rng_kind;
	logic [127:0]   rng_lo, rng_hi;
	logic [64:0]    full_key;
	logic [187:0]   half_key;
	int             errors, samples_checked;

	ckb_key_builder i_dut (.clk, .sys_rst, .frm_valid, .full_key_type, .lookup_idx, .ingress_port, .dmac,
		.etype, .is_ipv4, .is_ipv6, .tag_count, .outer_tag_type(ott), .outer_vid(ovid), .outer_dei(odei),
		.outer_pcp(opcp), .inner_tag_type, .inner_vlan_id, .inner_drop_eligible, .inner_priority,
		.src_l4_port, .dst_l4_port, .dscp_xlated, .ip_payload_word, .normal_key_sel, .inner_tag_select,
		.port_vid, .port_dei, .port_pcp, .rng_kind, .rng_lo, .rng_hi, .key_valid, .key_taken, .full_key,
		.half_key, .frm_ready);
	ckb_match_model i_far (.clk, .sys_rst, .key_valid, .slow, .key_taken);

	task automatic summarize();
		$display("checked %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic check(input logic [187:0] seen, input logic [187:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	function automatic logic inr(input logic [15:0] x, input int g);
		return x >= rng_lo[g*16 +: 16] && x <= rng_hi[g*16 +: 16];
	endfunction
	function automatic logic [187:0] exp_key();
		logic [187:0] k;
		logic [16:0]  it;
		logic [15:0]  v;
		k = '0;
		it = {inner_priority, inner_drop_eligible, inner_vlan_id, inner_tag_type};
		k[1:0] = full_key_type;
		k[3:2] = lookup_idx;
		k[4 + ingress_port] = 1'b1;
		k[25] = etype == 16'h8902;
		k[26] = dmac[40];
		k[27] = &dmac;
		k[28] = (is_ipv4 && dmac[47:23] == 25'h0200BC) || (is_ipv6 && dmac[47:32] == 16'h3333);
		k[29] = tag_count != 2'h0;
		k[30] = tag_count[1];
		if (!k[29]) k[47:31] = {port_pcp, port_dei, port_vid, 1'b0};
		else if (normal_key_sel && inner_tag_select && k[30]) k[47:31] = it;
		else k[47:31] = {opcp, odei, ovid, ott};
		if (k[30]) k[64:48] = it;
		v = {4'h0, k[29] ? ovid : port_vid};
		for (int g = 0; g < 8; g++) begin
			case (rng_kind[g*3 +: 3])
				3'h0: k[148+g] = inr(src_l4_port, g);
				3'h1: k[148+g] = inr(dst_l4_port, g);
				3'h2: k[148+g] = inr(src_l4_port, g) || inr(dst_l4_port, g);
				3'h3: k[148+g] = inr(v, g);
				3'h4: k[148+g] = inr({10'h000, dscp_xlated}, g);
				default: ;
			endcase
		end
		k[187:156] = ip_payload_word;
		return k;
	endfunction
	// One key per call; inputs are disturbed while the key is held
	task automatic send();
		logic [187:0] e;
		logic         tk;
		int           n;
		e = exp_key();
		frm_valid = 1'b1;
		n = 0;
		while (frm_ready !== 1'b1 && n++ < 50) @(negedge clk);
		@(negedge clk);
		frm_valid = 1'b0;
		ip_payload_word = ~ip_payload_word;
		check(188'(key_valid), 188'h1);
		check(188'(full_key[24:16]), 188'h0);
		n = 0;
		do begin
			check(188'(full_key), 188'(e[64:0]));
			check(half_key, e);
			check(188'(frm_ready), 188'h0);
			tk = key_taken;
			@(negedge clk);
		end while (tk !== 1'b1 && n++ < 20);
		check(188'(key_valid), 188'h0);
	endtask
	task automatic t_fields();
		for (int i = 0; i < 12; i++) begin
			full_key_type = ckb_full_type_t'(i % 3);
			lookup_idx = 2'((i / 3) % 3);
			ingress_port = 4'(i);
			send();
		end
		$display("fields done");
	endtask
	task automatic t_mac();
		logic [47:0] m [6] = '{48'hFFFFFFFFFFFF, 48'h01005E7F0001, 48'h01005E800001, 48'h333300000001,
			48'h333300000001, 48'h01005E000001};
		for (int i = 0; i < 6; i++) begin
			dmac = m[i];
			is_ipv4 = 6'b010111 >> i;
			is_ipv6 = !is_ipv4;
			etype = i[0] ? 16'h8902 : 16'h8903;
			send();
		end
		$display("mac done");
	endtask
	task automatic t_tags();
		slow = 1'b1;
		for (int i = 0; i < 16; i++) begin
			tag_count = 2'(i);
			inner_tag_select = i[2];
			normal_key_sel = i[3];
			ott = i[0];
			inner_tag_type = !i[0];
			send();
		end
		slow = 1'b0;
		$display("tags done");
	endtask
	task automatic t_range();
		logic [15:0] b [4] = '{16'h000F, 16'h0010, 16'h0020, 16'h0021};
		for (int i = 0; i < 4; i++) begin
			src_l4_port = b[i];
			dst_l4_port = b[3-i];
			dscp_xlated = b[i][5:0];
			port_vid = b[i][11:0];
			ovid = b[3-i][11:0];
			tag_count = 2'(i & 1);
			send();
		end
		$display("range done");
	endtask

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		#100000;
		errors++;
		summarize();
	end
	initial begin
		{sys_rst, frm_valid, slow, normal_key_sel, inner_tag_select} = 5'b10000;
		{full_key_type, lookup_idx, ingress_port, tag_count} = '0;
		{dmac, etype, is_ipv4, is_ipv6} = {48'h0A0000000001, 16'h0800, 2'b10};
		{ott, ovid, odei, opcp, port_vid, port_dei, port_pcp} = {1'b0, 12'h123, 1'b1, 3'h5, 12'h789, 1'b0, 3'h6};
		{inner_tag_type, inner_vlan_id, inner_drop_eligible, inner_priority} = {1'b1, 12'h456, 1'b0, 3'h2};
		{src_l4_port, dst_l4_port, dscp_xlated, ip_payload_word} = {16'h0015, 16'h0030, 6'h12, 32'hDEADBEEF};
		for (int g = 0; g < 8; g++) begin
			rng_kind[g*3 +: 3] = 3'(g);
			rng_lo[g*16 +: 16] = 16'h0010;
			rng_hi[g*16 +: 16] = 16'h0020;
		end
		repeat (10) @(negedge clk);
		sys_rst = 1'b0;
		check(188'({frm_ready, key_valid}), 188'h2);
		check(188'(full_key), 188'h0);
		check(half_key, 188'h0);
		t_fields();
		t_mac();
		t_tags();
		t_range();
		summarize();
	end
endmodule

// ---- verification/ckb_match_model.sv ----
`timescale 1ns/100ps
module ckb_match_model (
	// Clock and reset
	input  wire logic clk,
	input  wire logic sys_rst,
	// Key handshake
	input  wire logic key_valid,
	input  wire logic slow,
	output logic      key_taken
);
	logic [3:0] wait_q;
	// Slow mode stalls the builder to expose hold faults
	// Counts on the rising edge so the bench never races the take
	always_ff @(posedge clk) begin
		if (sys_rst || !key_valid) wait_q <= 4'h0;
		else if (wait_q != 4'hF) wait_q <= wait_q + 4'h1;
	end
	assign key_taken = key_valid && (wait_q >= (slow ? 4'h6 : 4'h0));
endmodule
